// [pkg/smpr_pkg.sv]
// Shared constants and types for the SPI memory and clock register engine
// Behaviour
// - Protect pin high allows all normal accesses
// - Pin low with pin-enable blocks status writes
// - Pin-enable clear makes protect pin ignored
// - Pin falling mid-frame keeps status write
// - No memory access while store busy
// - Read: opcode, two address bytes, MSB out
// - Read burst increments address, wraps to zero
// - Write burst stores next address, wraps zero
// - Write sequence end clears write enable
// - Protected locations skipped, address keeps advancing
// - Clock read: opcode, address, register out
// - Clock read burst wraps after register fifteen
// - Clock write burst wraps after register fifteen
// - Clock write needs write enable set
// - Non-flags clock writes need hold bit
// - Hold bit clear loads clock counters
// - Clock write end clears write enable
// - Block bits protect none, quarter, half, all
// - Write commands ignored while enable clear
// - Status write loads bits 7 to 2, clears write enable
package smpr_pkg;
	// ==========================================================
	// Array and clock register geometry
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int RTC_AW = 4;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
	localparam logic [RTC_AW-1:0] RTC_STEP = 4'h1;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_SET_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_MEM_READ = 8'h03;
	localparam logic [7:0] OP_MEM_WRITE = 8'h02;
	localparam logic [7:0] OP_CLOCK_REG_READ = 8'h13;
	localparam logic [7:0] OP_CLOCK_REG_WRITE = 8'h12;
	// ==========================================================
	// Status byte layout
	localparam int SR_PEN_BIT = 7;
	localparam int SR_BP_HI_BIT = 3;
	localparam int SR_BP_LO_BIT = 2;
	localparam int SR_WEN_BIT = 1;
	localparam int SR_RDY_BIT = 0;
	localparam logic [2:0] SR_SPARE_RST = 3'h0;
	// ==========================================================
	// Block protect codes
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] QTR_SEG = 2'h3;
	// ==========================================================
	// Clock flags register
	localparam logic [RTC_AW-1:0] RTC_FLAGS_ADDR = 4'h0;
	localparam int RTC_W_BIT = 1;
	localparam int RTC_R_BIT = 0;
	localparam logic [DATA_W-1:0] RTC_RST = 8'h00;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_SET_WRITE_ENABLE_CMD, CMD_WRDIS, CMD_RDSR, CMD_STATUS_WRITE_CMD,
		CMD_READ, CMD_WRITE, CMD_RDCLK, CMD_WRCLK
	} smpr_cmd_e;

	typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DATA, PH_IGNORE} smpr_phase_e;
endpackage

// [hdl/smpr_sync.sv]
// Two-flop level synchroniser, any width
`timescale 1ns/1ns
module smpr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic clr,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q_r
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (clr) begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
endmodule // smpr_sync

// [hdl/smpr_mem.sv]
// Byte array with one write port and one asynchronous read port
`timescale 1ns/1ns
module smpr_mem #(
	parameter int AW = 15,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem_r [2**AW];

	// Data array holds no reset: contents are user data
	always_ff @(posedge clk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	assign rdata = mem_r[raddr];
endmodule // smpr_mem

// [hdl/smpr_top.sv]
// SPI command engine: protection, array bursts, clock register bursts
`timescale 1ns/1ns
module smpr_top
	import smpr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe_n,
	input wire logic write_protect_n,
	input wire logic hardware_store_busy_pin_n,
	output logic write_enable,
	output logic protect_pin_enable_bit,
	output logic block_protect_high_bit,
	output logic block_protect_low_bit,
	output logic clock_write_hold,
	output logic clock_read_freeze,
	output logic clock_counter_load
);
	// ==========================================================
	// System clock side: pins, status byte, end-of-frame effects
	logic cs_s, wp_s, hsb_n_s, cs_d_r, link_rst_r, wp_start_r;
	logic wen_r, pen_r, bp_hi_r, bp_lo_r;
	logic [2:0] spare_r;
	logic hold_r, freeze_r, load_pls_r;
	logic cs_rise, cs_fall;
	logic [7:0] sr_sys;
	// Link side results, stable while chip select is high
	smpr_cmd_e fr_cmd_r;
	logic fr_sr_valid_r, fr_wen_clr_r, fr_w_fell_r;
	logic [DATA_W-1:0] fr_sr_data_r;
	logic [DATA_W-1:0] rtc_mem_r [2**RTC_AW];

	// Asynchronous pins pass two flops first
	smpr_sync #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
		.clk(sys_clk),
		.clr(!resetn),
		.d({spi_cs_n, write_protect_n, hardware_store_busy_pin_n}),
		.q_r({cs_s, wp_s, hsb_n_s})
	);

	assign cs_rise = cs_s && !cs_d_r;
	assign cs_fall = !cs_s && cs_d_r;
	assign sr_sys = {pen_r, spare_r, bp_hi_r, bp_lo_r, wen_r, !hsb_n_s};

	// Edge history and a reset that clears the link side without a clock
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cs_d_r <= 1'b1;
			link_rst_r <= 1'b1;
		end else begin
			cs_d_r <= cs_s;
			link_rst_r <= 1'b0;
		end
	end

	// Pin level is frozen at frame start so a late fall cannot abort
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wp_start_r <= 1'b1;
		end else if (cs_fall) begin
			wp_start_r <= wp_s;
		end
	end

	// Status byte and write enable latch, updated when the frame closes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wen_r <= 1'b0;
			pen_r <= 1'b0;
			bp_hi_r <= 1'b0;
			bp_lo_r <= 1'b0;
			spare_r <= SR_SPARE_RST;
		end else if (cs_rise) begin
			if (fr_cmd_r == CMD_SET_WRITE_ENABLE_CMD) begin
				wen_r <= 1'b1;
			end else if (fr_cmd_r == CMD_WRDIS) begin
				wen_r <= 1'b0;
			end else if (fr_cmd_r == CMD_STATUS_WRITE_CMD && fr_sr_valid_r) begin
				wen_r <= 1'b0;
				// Pin only counts while the pin-enable bit is set
				if (!(pen_r && !wp_start_r)) begin
					pen_r <= fr_sr_data_r[SR_PEN_BIT];
					spare_r <= fr_sr_data_r[6:4];
					bp_hi_r <= fr_sr_data_r[SR_BP_HI_BIT];
					bp_lo_r <= fr_sr_data_r[SR_BP_LO_BIT];
				end
			end else if (fr_wen_clr_r) begin
				wen_r <= 1'b0;
			end
		end
	end

	// Clock control levels follow the flags register at frame end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hold_r <= 1'b0;
			freeze_r <= 1'b0;
			load_pls_r <= 1'b0;
		end else begin
			load_pls_r <= cs_rise && fr_w_fell_r;
			if (cs_rise) begin
				hold_r <= rtc_mem_r[RTC_FLAGS_ADDR][RTC_W_BIT];
				freeze_r <= rtc_mem_r[RTC_FLAGS_ADDR][RTC_R_BIT];
			end
		end
	end

	assign write_enable = wen_r;
	assign protect_pin_enable_bit = pen_r;
	assign block_protect_high_bit = bp_hi_r;
	assign block_protect_low_bit = bp_lo_r;
	assign clock_write_hold = hold_r;
	assign clock_read_freeze = freeze_r;
	assign clock_counter_load = load_pls_r;

	// ==========================================================
	// Link side: serial clock domain
	logic [7:0] sr_s;
	logic wen_s, busy_s;
	logic [1:0] bp_s;
	logic [2:0] bit_cnt_r;
	logic [6:0] sh_r;
	smpr_phase_e phase_r, op_phase;
	smpr_cmd_e cmd_r, op_cmd;
	logic addr_hi_r, load_r, byte_done, is_clk, rd_cmd, mem_we, rtc_we;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [RTC_AW-1:0] rtc_a;
	logic [DATA_W-1:0] byte_in, mem_rdata, rd_byte;
	logic [7:0] so_sh_r;
	logic so_r, so_oe_n_r;

	// Status byte is static during a frame; settles within two edges
	smpr_sync #(.W(8), .RST_VAL(8'h00)) u_sr_sync (
		.clk(spi_sck),
		.clr(1'b0),
		.d(sr_sys),
		.q_r(sr_s)
	);

	assign wen_s = sr_s[SR_WEN_BIT];
	assign busy_s = sr_s[SR_RDY_BIT];
	assign bp_s = {sr_s[SR_BP_HI_BIT], sr_s[SR_BP_LO_BIT]};
	assign byte_in = {sh_r, spi_si};
	assign byte_done = bit_cnt_r == BIT_LAST;
	assign is_clk = cmd_r == CMD_RDCLK || cmd_r == CMD_WRCLK;
	assign rd_cmd = cmd_r == CMD_READ || cmd_r == CMD_RDCLK
		|| cmd_r == CMD_RDSR;
	assign rtc_a = addr_r[RTC_AW-1:0];

	// Block protect map: none, top quarter, top half, whole array
	function automatic logic is_prot(input logic [ADDR_W-1:0] a,
		input logic [1:0] bp);
		if (bp == BP_NONE) begin
			is_prot = 1'b0;
		end else if (bp == BP_QUARTER) begin
			is_prot = a[ADDR_W-1 -: 2] == QTR_SEG;
		end else if (bp == BP_HALF) begin
			is_prot = a[ADDR_W-1];
		end else begin
			is_prot = 1'b1;
		end
	endfunction

	// Opcode decode; write types fall to ignore while enable is clear
	always_comb begin
		op_cmd = CMD_NONE;
		op_phase = PH_IGNORE;
		if (byte_in == OP_SET_WRITE_ENABLE) begin
			op_cmd = CMD_SET_WRITE_ENABLE_CMD;
		end else if (byte_in == OP_WRITE_DISABLE) begin
			op_cmd = CMD_WRDIS;
		end else if (byte_in == OP_STATUS_READ) begin
			op_cmd = CMD_RDSR;
			op_phase = PH_DATA;
		end else if (byte_in == OP_STATUS_WRITE && wen_s) begin
			op_cmd = CMD_STATUS_WRITE_CMD;
			op_phase = PH_DATA;
		end else if (byte_in == OP_MEM_READ && !busy_s) begin
			op_cmd = CMD_READ;
			op_phase = PH_ADDR;
		end else if (byte_in == OP_MEM_WRITE && wen_s && !busy_s) begin
			op_cmd = CMD_WRITE;
			op_phase = PH_ADDR;
		end else if (byte_in == OP_CLOCK_REG_READ) begin
			op_cmd = CMD_RDCLK;
			op_phase = PH_ADDR;
		end else if (byte_in == OP_CLOCK_REG_WRITE && wen_s) begin
			op_cmd = CMD_WRCLK;
			op_phase = PH_ADDR;
		end
	end

	// Clock registers wrap inside sixteen; array wraps at the top
	always_comb begin
		if (is_clk) begin
			addr_nxt = {{(ADDR_W-RTC_AW){1'b0}}, rtc_a + RTC_STEP};
		end else begin
			addr_nxt = addr_r + ADDR_STEP;
		end
	end

	// Protected bytes are dropped while the address still advances
	assign mem_we = phase_r == PH_DATA && byte_done && cmd_r == CMD_WRITE
		&& !is_prot(addr_r, bp_s);
	// Flags register always writable; the rest need the hold bit
	assign rtc_we = phase_r == PH_DATA && byte_done && cmd_r == CMD_WRCLK
		&& (rtc_a == RTC_FLAGS_ADDR
		|| rtc_mem_r[RTC_FLAGS_ADDR][RTC_W_BIT]);

	// Frame state, cleared without a clock when chip select rises
	always_ff @(posedge spi_sck or posedge spi_cs_n or posedge link_rst_r) begin
		if (link_rst_r || spi_cs_n) begin
			bit_cnt_r <= '0;
			sh_r <= '0;
			phase_r <= PH_OP;
			cmd_r <= CMD_NONE;
			addr_hi_r <= 1'b0;
			addr_r <= '0;
			load_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + BIT_STEP;
			sh_r <= byte_in[6:0];
			load_r <= 1'b0;
			if (byte_done) begin
				case (phase_r)
				PH_OP: begin
					cmd_r <= op_cmd;
					phase_r <= op_phase;
					load_r <= op_cmd == CMD_RDSR;
				end
				PH_ADDR: begin
					if (is_clk) begin
						// Top four address bits are not used
						addr_r <= {{(ADDR_W-RTC_AW){1'b0}},
							byte_in[RTC_AW-1:0]};
						phase_r <= PH_DATA;
						load_r <= cmd_r == CMD_RDCLK;
					end else if (!addr_hi_r) begin
						addr_r[ADDR_W-1:8] <= byte_in[6:0];
						addr_hi_r <= 1'b1;
					end else begin
						addr_r[7:0] <= byte_in;
						phase_r <= PH_DATA;
						load_r <= cmd_r == CMD_READ;
					end
				end
				PH_DATA: begin
					addr_r <= addr_nxt;
					load_r <= rd_cmd;
					if (cmd_r == CMD_STATUS_WRITE_CMD) begin
						phase_r <= PH_IGNORE;
					end
				end
				default: begin
					phase_r <= PH_IGNORE;
				end
				endcase
			end
		end
	end

	// Clock registers and frame results survive chip select high
	always_ff @(posedge spi_sck or posedge link_rst_r) begin
		if (link_rst_r) begin
			for (int i = 0; i < 2**RTC_AW; i++) begin
				rtc_mem_r[i] <= RTC_RST;
			end
			fr_cmd_r <= CMD_NONE;
			fr_sr_valid_r <= 1'b0;
			fr_sr_data_r <= '0;
			fr_wen_clr_r <= 1'b0;
			fr_w_fell_r <= 1'b0;
		end else begin
			if (phase_r == PH_OP && bit_cnt_r == '0) begin
				fr_cmd_r <= CMD_NONE;
				fr_sr_valid_r <= 1'b0;
				fr_wen_clr_r <= 1'b0;
				fr_w_fell_r <= 1'b0;
			end else if (phase_r == PH_OP && byte_done) begin
				fr_cmd_r <= op_cmd;
			end else if (phase_r == PH_DATA && byte_done) begin
				if (cmd_r == CMD_STATUS_WRITE_CMD) begin
					fr_sr_valid_r <= 1'b1;
					fr_sr_data_r <= byte_in;
				end
				// Any data byte completes a write sequence
				if (cmd_r == CMD_WRITE || cmd_r == CMD_WRCLK) begin
					fr_wen_clr_r <= 1'b1;
				end
			end
			if (rtc_we) begin
				rtc_mem_r[rtc_a] <= byte_in;
				if (rtc_a == RTC_FLAGS_ADDR
					&& rtc_mem_r[RTC_FLAGS_ADDR][RTC_W_BIT]
					&& !byte_in[RTC_W_BIT]) begin
					fr_w_fell_r <= 1'b1;
				end
			end
		end
	end

	smpr_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
		.clk(spi_sck),
		.we(mem_we),
		.waddr(addr_r),
		.wdata(byte_in),
		.raddr(addr_r),
		.rdata(mem_rdata)
	);

	// Source of the outgoing byte
	always_comb begin
		if (cmd_r == CMD_RDSR) begin
			rd_byte = sr_s;
		end else if (cmd_r == CMD_RDCLK) begin
			rd_byte = rtc_mem_r[rtc_a];
		end else begin
			rd_byte = mem_rdata;
		end
	end

	// Output shifts on falling edges; released as soon as select rises
	always_ff @(negedge spi_sck or posedge spi_cs_n or posedge link_rst_r) begin
		if (link_rst_r || spi_cs_n) begin
			so_sh_r <= '0;
			so_r <= 1'b0;
			so_oe_n_r <= 1'b1;
		end else if (load_r) begin
			so_r <= rd_byte[7];
			so_sh_r <= {rd_byte[6:0], 1'b0};
			so_oe_n_r <= 1'b0;
		end else begin
			so_r <= so_sh_r[7];
			so_sh_r <= {so_sh_r[6:0], 1'b0};
		end
	end

	assign spi_so = so_r;
	assign spi_so_oe_n = so_oe_n_r;

	// ==========================================================
	// Checks
	a_sr_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && pen_r && !wp_start_r |=> $stable({pen_r, bp_hi_r, bp_lo_r}))
		else $error("status changed while pin locked");
	a_sr_free: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && fr_cmd_r == CMD_STATUS_WRITE_CMD && fr_sr_valid_r && !pen_r
		|=> {bp_hi_r, bp_lo_r} == $past(fr_sr_data_r[3:2]) && !wen_r)
		else $error("status write lost with pin-enable clear");
	a_wen_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && fr_wen_clr_r && fr_cmd_r != CMD_SET_WRITE_ENABLE_CMD |=> !wen_r)
		else $error("write enable not cleared after write");
	a_load_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
		cs_rise && fr_w_fell_r |=> clock_counter_load ##1 !clock_counter_load)
		else $error("counter load not a single pulse");
	a_mem_wrap: assert property (@(posedge spi_sck)
		disable iff (spi_cs_n || link_rst_r)
		phase_r == PH_DATA && byte_done && !is_clk && rd_cmd == (cmd_r == CMD_READ)
		&& cmd_r inside {CMD_READ, CMD_WRITE} && &addr_r |=> addr_r == '0)
		else $error("array address did not wrap");
	a_rtc_wrap: assert property (@(posedge spi_sck)
		disable iff (spi_cs_n || link_rst_r)
		phase_r == PH_DATA && byte_done && is_clk && &rtc_a |=> addr_r == '0)
		else $error("clock register address did not wrap");
	a_prot_skip: assert property (@(posedge spi_sck)
		disable iff (spi_cs_n || link_rst_r)
		mem_we |-> !is_prot(addr_r, bp_s) && wen_s)
		else $error("write reached protected byte");
	a_hold_gate: assert property (@(posedge spi_sck)
		disable iff (spi_cs_n || link_rst_r)
		rtc_we && rtc_a != RTC_FLAGS_ADDR |-> rtc_mem_r[RTC_FLAGS_ADDR][RTC_W_BIT])
		else $error("clock register written without hold");
	a_busy_block: assert property (@(posedge spi_sck)
		disable iff (spi_cs_n || link_rst_r)
		phase_r == PH_OP && byte_done && busy_s
		|=> cmd_r != CMD_READ && cmd_r != CMD_WRITE)
		else $error("array access accepted while busy");
	c_burst_wrap: cover property (@(posedge spi_sck)
		mem_we && &addr_r);
	c_rtc_load: cover property (@(posedge sys_clk) clock_counter_load);
	c_sr_reject: cover property (@(posedge sys_clk)
		cs_rise && fr_cmd_r == CMD_STATUS_WRITE_CMD && pen_r && !wp_start_r);
endmodule // smpr_top

// [dv/smpr_host.sv]
// Behavioural SPI host that drives frames into the memory engine
`timescale 1ns/1ns
module smpr_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si,
	input wire logic spi_so
);
	// ==========================================================
	// Frame queues and link clock pacing
	logic [7:0] tq[$];
	logic [7:0] rq[$];
	int half_ns = 6;

	// Clock parked low, select released between frames
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end

	// ==========================================================
	// One frame: mode 0, data set while clock low, sampled on rise
	task automatic run();
		logic [7:0] tx;
		logic [7:0] rx;
		rq = {};
		spi_cs_n = 1'b0;
		while (tq.size() > 0) begin
			tx = tq.pop_front();
			for (int i = 7; i >= 0; i--) begin
				spi_si = tx[i];
				#(half_ns) spi_sck = 1'b1;
				rx[i] = spi_so;
				#(half_ns) spi_sck = 1'b0;
			end
			rq.push_back(rx);
		end
		// Select lifted right after the last bit
		#(half_ns) spi_cs_n = 1'b1;
		// Released data line must not keep its last value
		spi_si = ~spi_si;
	endtask
endmodule // smpr_host

// [dv/spi_memory_rtc_access_protect_tb.sv]
// Self-checking bench for the SPI memory and clock register engine
`timescale 1ns/1ns
module spi_memory_rtc_access_protect_tb;
	import smpr_pkg::*;
	// ==========================================================
	// Design signals
	logic sys_clk, resetn, write_protect_n, busy_n;
	logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
	logic write_enable, protect_pin_enable_bit;
	logic block_protect_high_bit, block_protect_low_bit;
	logic clock_write_hold, clock_read_freeze, clock_counter_load;
	// Reference model state and bookkeeping
	int mem[32768];
	int rtc[16];
	int wen, pen, bp, n_load, seed, n_errors, checked;
	logic [7:0] dq[$];

	smpr_top dut (.sys_clk(sys_clk), .resetn(resetn), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n), .write_protect_n(write_protect_n),
		.hardware_store_busy_pin_n(busy_n), .write_enable(write_enable),
		.protect_pin_enable_bit(protect_pin_enable_bit),
		.block_protect_high_bit(block_protect_high_bit),
		.block_protect_low_bit(block_protect_low_bit),
		.clock_write_hold(clock_write_hold),
		.clock_read_freeze(clock_read_freeze),
		.clock_counter_load(clock_counter_load));
	smpr_host u_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so(spi_so));

	// ==========================================================
	// Clock and counter load pulse tally
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Sampled off the launching edge so the flop has settled
	always @(negedge sys_clk) begin
		if (clock_counter_load === 1'b1) n_load++;
	end

	// ==========================================================
	// Comparison, verdict and frame helpers
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Gap after each frame covers the sync plus edge detect delay
	task automatic frame();
		u_host.run();
		repeat (8) @(negedge sys_clk);
		check("oe_n_idle", 8'(spi_so_oe_n), 8'h01);
	endtask
	function automatic bit prot(input int a);
		return bp == 3 || (bp == 2 && a >= 16'h4000) ||
			(bp == 1 && a >= 16'h6000);
	endfunction
	task automatic set_write_enable_cmd();
		u_host.tq = {OP_SET_WRITE_ENABLE};
		frame();
		wen = 1;
		check("wen_set", 8'(write_enable), 8'h01);
	endtask
	task automatic status();
		u_host.tq = {OP_STATUS_READ, 8'h00};
		frame();
		check("pen", 8'(protect_pin_enable_bit), 8'(pen));
		check("bp_hi", 8'(block_protect_high_bit), 8'(bp >> 1));
		check("bp_lo", 8'(block_protect_low_bit), 8'(bp & 1));
		check("status", u_host.rq[1], 8'((pen << 7) | (bp << 2) |
			(wen << 1) | (busy_n ? 0 : 1)));
	endtask
	// Pin level at frame start decides; a mid-frame drop is ignored
	task automatic sr_write(input int v, input bit drop_wp);
		set_write_enable_cmd();
		if (pen == 0 || write_protect_n) begin
			pen = (v >> 7) & 1;
			bp = (v >> 2) & 3;
		end
		u_host.tq = {OP_STATUS_WRITE, 8'(v)};
		fork
			u_host.run();
			if (drop_wp) begin
				repeat (5) @(negedge sys_clk);
				write_protect_n = 1'b0;
			end
		join
		repeat (8) @(negedge sys_clk);
		wen = 0;
		status();
	endtask
	// Top address bit set on purpose: it must be ignored
	task automatic mem_wr(input int a, input int n, input bit en);
		int v;
		if (en) set_write_enable_cmd();
		u_host.tq = {OP_MEM_WRITE, 8'((a >> 8) | 8'h80), 8'(a)};
		for (int i = 0; i < n; i++) begin
			v = $random(seed) & 8'hff;
			u_host.tq.push_back(8'(v));
			if (wen && !prot((a + i) & 16'h7fff))
				mem[(a + i) & 16'h7fff] = v;
		end
		frame();
		wen = 0;
		check("wen_after_write", 8'(write_enable), 8'h00);
	endtask
	task automatic mem_rd(input int a, input int n);
		u_host.tq = {OP_MEM_READ, 8'((a >> 8) | 8'h80), 8'(a)};
		repeat (n) u_host.tq.push_back(8'h00);
		frame();
		for (int i = 0; i < n; i++)
			check("mem_read", u_host.rq[3 + i],
				8'(mem[(a + i) & 16'h7fff]));
	endtask
	task automatic clk_wr(input int a, input bit en);
		int h;
		if (en) set_write_enable_cmd();
		h = rtc[0] & 2;
		u_host.tq = {OP_CLOCK_REG_WRITE, 8'(a)};
		for (int i = 0; i < dq.size(); i++) begin
			u_host.tq.push_back(dq[i]);
			if (wen && (h != 0 || ((a + i) & 15) == 0))
				rtc[(a + i) & 15] = dq[i];
		end
		frame();
		wen = 0;
		check("wen_after_clock", 8'(write_enable), 8'h00);
		check("hold", 8'(clock_write_hold), 8'((rtc[0] >> 1) & 1));
		check("freeze", 8'(clock_read_freeze), 8'(rtc[0] & 1));
	endtask
	// Register reads slowed to the clock register rate
	task automatic clk_rd(input int a, input int n);
		u_host.half_ns = 20;
		u_host.tq = {OP_CLOCK_REG_READ, 8'(a)};
		repeat (n) u_host.tq.push_back(8'h00);
		frame();
		u_host.half_ns = 6;
		for (int i = 0; i < n; i++)
			check("clock_read", u_host.rq[2 + i],
				8'(rtc[(a + i) & 15]));
	endtask

	// ==========================================================
	// Hang guard
	initial begin
		#500000;
		n_errors++;
		$display("MISMATCH watchdog expected done seen running");
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		int ld;
		seed = 42439;
		resetn = 1'b0;
		write_protect_n = 1'b1;
		busy_n = 1'b1;
		repeat (12) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		// Status write protection
		write_protect_n = 1'b0;
		sr_write(8'h04, 1'b0);
		sr_write(8'h80, 1'b0);
		sr_write(8'h0c, 1'b0);
		write_protect_n = 1'b1;
		sr_write(8'h80, 1'b1);
		write_protect_n = 1'b1;
		busy_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		status();
		busy_n = 1'b1;
		$display("status protection tests done");
		// Every block protect level, bursts across boundaries and wrap
		for (int b = 0; b < 4; b++) begin
			sr_write(8'h80 | (b << 2), 1'b0);
			mem_wr(16'h3ffe, 4, 1'b1);
			mem_wr(16'h5ffe, 4, 1'b1);
			mem_wr(16'h7ffe, 4, 1'b1);
			mem_rd(16'h3ffe, 4);
			mem_rd(16'h5ffe, 4);
			mem_rd(16'h7ffe, 4);
		end
		sr_write(8'h00, 1'b0);
		mem_wr(16'h3fff, 2, 1'b0);
		mem_rd(16'h3fff, 2);
		$display("array burst tests done");
		// Clock registers: enable, hold, wrap, load on hold clear
		dq = {8'h02};
		clk_wr(8'h00, 1'b0);
		clk_wr(8'h00, 1'b1);
		ld = n_load;
		dq = {8'($random(seed)), 8'($random(seed)), 8'h01};
		clk_wr(8'h0e, 1'b1);
		check("load_pulses", 8'(n_load), 8'(ld + 1));
		clk_rd(8'h0f, 3);
		dq = {8'($random(seed))};
		clk_wr(8'h05, 1'b1);
		clk_rd(8'h05, 1);
		dq = {8'h00};
		clk_wr(8'h00, 1'b1);
		check("load_pulses", 8'(n_load), 8'(ld + 1));
		$display("clock register tests done");
		close_out();
	end
endmodule // spi_memory_rtc_access_protect_tb
